// ### design/cicr_consts.svh
// Constants of the core interrupt gate: register offsets, bit positions,
// reset values and widths.
// Assumes a 12-bit APB byte address and 32-bit data.
`ifndef CICR_CONSTS_SVH
`define CICR_CONSTS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CICR_OFS_GATE     12'h000
`define CICR_OFS_MASK     12'h004
`define CICR_OFS_STS      12'h008
`define CICR_OFS_CLR      12'h00c
`define CICR_OFS_EN       12'h010

// ****************************************************************
// Bit positions in interrupt_gate_and_flags
// ****************************************************************
`define CICR_BIT_GIE      7
`define CICR_BIT_PERIPHERAL_GROUP_IRQ_ENABLE     6
`define CICR_BIT_TIMER_OVERFLOW_IRQ_ENABLE     5
`define CICR_BIT_EXTIE    4
`define CICR_BIT_PCIE     3
`define CICR_BIT_T0F      2
`define CICR_BIT_EXTF     1
`define CICR_BIT_PCF      0

// ****************************************************************
// Mask register layout and event bits
// ****************************************************************
`define CICR_NPINS        16
`define CICR_NSYNC        17
`define CICR_BIT_EXTPIN   16
`define CICR_BIT_EDGE     16
`define CICR_NEVT         3
`define CICR_EVT_TMR      0
`define CICR_EVT_EXT      1
`define CICR_EVT_PORT     2

// ****************************************************************
// Reset values
// ****************************************************************
`define CICR_GATE_RST     8'h00
`define CICR_MASK_RST     17'h1_0000
`define CICR_STS_RST      3'h0
`define CICR_EN_RST       3'h0

`endif

// ### design/cicr_pin_if.sv
// Carrier between the pin synchroniser and the interrupt gate.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
`include "cicr_consts.svh"

interface cicr_pin_if;
    logic [`CICR_NSYNC-1:0] level;
    logic [`CICR_NSYNC-1:0] chg;
    modport sync_side (output level, output chg);
    modport core_side (input level, input chg);
endinterface : cicr_pin_if

// ### design/cicr_pin_sync.sv
// Two-flop synchroniser and change detector for the external interrupt
// pin and the general I/O port pins.
// Assumes raw pins are asynchronous to pclk.
`timescale 1ns/1ps
`include "cicr_consts.svh"

module cicr_pin_sync
    import cicr_pkg::*;
(
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire cicr_pkg::cicr_pin_type pin_raw,
    cicr_pin_if.sync_side        pins
);
    import cicr_pkg::*;

    cicr_pin_type meta_q;
    cicr_pin_type sync_q;
    cicr_pin_type prev_q;

    // ****************************************************************
    // Per-pin synchroniser
    // ****************************************************************
    // Only the second and third stages are looked at, the first may be metastable
    for (genvar i = 0; i < `CICR_NSYNC; i++) begin : g_pin
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                meta_q[i] <= 1'b0;
                sync_q[i] <= 1'b0;
                prev_q[i] <= 1'b0;
            end else begin
                meta_q[i] <= pin_raw[i];
                sync_q[i] <= meta_q[i];
                prev_q[i] <= sync_q[i];
            end
        end
    end

    assign pins.level = sync_q;
    assign pins.chg   = sync_q ^ prev_q;
endmodule : cicr_pin_sync

// ### design/cicr_pkg.sv
// Types shared by the core interrupt gate files.
// Assumes cicr_consts.svh is on the include path.
`include "cicr_consts.svh"

package cicr_pkg;
    typedef logic [7:0]                 cicr_gate_type;
    typedef logic [`CICR_NEVT-1:0]      cicr_evt_type;
    typedef logic [`CICR_NSYNC-1:0]     cicr_pin_type;
endpackage : cicr_pkg

// ### design/cicr_top.sv
// Core interrupt gate: global and group enables, per-source enables and
// sticky flags, pin change masking, APB register slave and event status.
// Assumes an APB master on pclk, a timer and peripheral logic on pclk,
// and asynchronous external and port pins.
//
// Summary of operation
// - Bit 7 is the global enable; when zero no request reaches the core.
// - Bit 6 lets peripheral requests through; when zero they are blocked.
// - Bit 5 lets the timer overflow flag raise a request.
// - Bit 4 lets the external pin flag raise a request.
// - Bit 3 lets the port change flag raise a request.
// - Bit 2 is set by a timer overflow and stays set until software clears it.
// - Bit 1 is set by the external pin edge that mask bit 16 selects and stays set until software clears it.
// - Bit 0 is set when a port pin changes and stays set until software clears it.
// - Flags set whatever the enable bits hold; software clears before enabling.
// - A port pin change counts only where its per-pin mask bit is set.
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "cicr_consts.svh"

module cicr_top
    import cicr_pkg::*;
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   timer_overflow,
    input  wire logic                   periph_irq,
    input  wire logic                   external_interrupt_pin,
    input  wire logic [`CICR_NPINS-1:0] general_io_ports,
    output logic                        core_irq_req,
    output logic                        irq
);
    import cicr_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    cicr_gate_type             gate_q;
    cicr_gate_type             gate_d;
    logic [`CICR_NSYNC-1:0]    mask_q;
    logic [`CICR_NSYNC-1:0]    mask_d;
    cicr_evt_type              sts_q;
    cicr_evt_type              sts_d;
    cicr_evt_type              en_q;
    cicr_evt_type              en_d;
    logic [31:0]               prdata_d;
    logic                      pready_d;
    logic                      pslverr_d;
    logic                      core_d;
    logic                      irq_d;

    // ****************************************************************
    // Pin synchroniser
    // ****************************************************************
    cicr_pin_if pins_if ();

    cicr_pin_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_raw ({external_interrupt_pin, general_io_ports}),
        .pins    (pins_if.sync_side)
    );

    // ****************************************************************
    // APB decode
    // ****************************************************************
    wire logic        acc      = psel & penable;
    wire logic        first    = acc & ~pready;
    wire logic        take     = acc & pready;
    wire logic        wr_fire  = take & pwrite;
    wire logic        sel_gate = (paddr == `CICR_OFS_GATE);
    wire logic        sel_mask = (paddr == `CICR_OFS_MASK);
    wire logic        sel_sts  = (paddr == `CICR_OFS_STS);
    wire logic        sel_clr  = (paddr == `CICR_OFS_CLR);
    wire logic        sel_en   = (paddr == `CICR_OFS_EN);
    wire logic        mapped   = sel_gate | sel_mask | sel_sts | sel_clr | sel_en;
    wire logic [31:0] lane_msk = {{8{pstrb[3]}}, {8{pstrb[2]}},
                                  {8{pstrb[1]}}, {8{pstrb[0]}}};
    wire logic        gate_wr  = wr_fire & sel_gate & pstrb[0];
    wire logic        mask_wr  = wr_fire & sel_mask;
    wire logic        clr_wr   = wr_fire & sel_clr & pstrb[0];
    wire logic        en_wr    = wr_fire & sel_en & pstrb[0];

    // ****************************************************************
    // Event detection
    // ****************************************************************
    wire logic edge_rise = mask_q[`CICR_BIT_EDGE];
    wire logic ext_edge  = pins_if.chg[`CICR_BIT_EXTPIN]
                         & (pins_if.level[`CICR_BIT_EXTPIN] == edge_rise);
    // Pins whose mask bit is clear never raise the port change flag
    wire logic port_evt  = |(pins_if.chg[`CICR_NPINS-1:0]
                         & mask_q[`CICR_NPINS-1:0]);
    wire cicr_evt_type evt = {port_evt, ext_edge, timer_overflow};

    // ****************************************************************
    // Gate and flag register
    // ****************************************************************
    // Hardware set wins over a software clear in the same cycle,
    // and flags set regardless of any enable bit.
    wire cicr_gate_type gate_soft = gate_wr ? pwdata[7:0] : gate_q;
    wire cicr_gate_type hw_set    = {5'h00, timer_overflow, ext_edge, port_evt};
    assign gate_d = gate_soft | hw_set;

    // Edge select rides above the sixteen pin mask bits
    wire logic [31:0] mask_new = ({15'h0000, mask_q} & ~lane_msk) | (pwdata & lane_msk);
    assign mask_d = mask_wr ? mask_new[`CICR_NSYNC-1:0] : mask_q;

    // ****************************************************************
    // Core request
    // ****************************************************************
    // Peripheral request is already masked per source outside
    wire logic periph_req = gate_q[`CICR_BIT_PERIPHERAL_GROUP_IRQ_ENABLE] & periph_irq;
    wire logic tmr_req    = gate_q[`CICR_BIT_TIMER_OVERFLOW_IRQ_ENABLE] & gate_q[`CICR_BIT_T0F];
    wire logic ext_req    = gate_q[`CICR_BIT_EXTIE] & gate_q[`CICR_BIT_EXTF];
    wire logic port_req   = gate_q[`CICR_BIT_PCIE] & gate_q[`CICR_BIT_PCF];
    wire logic src_req    = tmr_req | ext_req | port_req | periph_req;
    assign core_d = gate_q[`CICR_BIT_GIE] & src_req;

    // ****************************************************************
    // Event status and system interrupt
    // ****************************************************************
    wire cicr_evt_type clr_bits = clr_wr ? pwdata[`CICR_NEVT-1:0] : `CICR_STS_RST;
    assign sts_d = (sts_q & ~clr_bits) | evt;
    assign en_d  = en_wr ? pwdata[`CICR_NEVT-1:0] : en_q;
    assign irq_d = |(sts_q & en_q);

    // ****************************************************************
    // Read mux and answer
    // ****************************************************************
    // One wait state keeps every APB output straight from a flop;
    // read data is sampled in the first access cycle.
    wire logic [31:0] rdata_w =
        sel_gate ? {24'h00_0000, gate_q} :
        sel_mask ? {15'h0000, mask_q} :
        sel_sts  ? {29'h0000_0000, sts_q} :
        sel_en   ? {29'h0000_0000, en_q} : 32'h0000_0000;

    assign pready_d  = first;
    assign prdata_d  = (first & ~pwrite) ? rdata_w : prdata;
    assign pslverr_d = first & ~mapped;

    // ****************************************************************
    // Flops
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_q <= `CICR_GATE_RST;
            mask_q <= `CICR_MASK_RST;
            sts_q  <= `CICR_STS_RST;
            en_q   <= `CICR_EN_RST;
        end else begin
            gate_q <= gate_d;
            mask_q <= mask_d;
            sts_q  <= sts_d;
            en_q   <= en_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata       <= 32'h0000_0000;
            pready       <= 1'b0;
            pslverr      <= 1'b0;
            core_irq_req <= 1'b0;
            irq          <= 1'b0;
        end else begin
            prdata       <= prdata_d;
            pready       <= pready_d;
            pslverr      <= pslverr_d;
            core_irq_req <= core_d;
            irq          <= irq_d;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_access;
        psel && penable;
    endsequence

    chk_apb_one_wait: assert property (
        s_setup ##1 s_access |-> !pready ##1 pready)
        else $error("APB answer not after exactly one wait state");

    chk_gie_blocks_core: assert property (
        !gate_q[`CICR_BIT_GIE] |=> !core_irq_req)
        else $error("Core request raised with global enable clear");

    chk_peripheral_group_irq_enable_blocks_periph: assert property (
        gate_q[`CICR_BIT_GIE] && !gate_q[`CICR_BIT_PERIPHERAL_GROUP_IRQ_ENABLE]
        && !tmr_req && !ext_req && !port_req |=> !core_irq_req)
        else $error("Peripheral request passed with group enable clear");

    chk_timer_path: assert property (
        gate_q[`CICR_BIT_GIE] && gate_q[`CICR_BIT_TIMER_OVERFLOW_IRQ_ENABLE] && gate_q[`CICR_BIT_T0F]
        |=> core_irq_req)
        else $error("Enabled timer flag did not request the core");

    chk_ext_path: assert property (
        gate_q[`CICR_BIT_GIE] && gate_q[`CICR_BIT_EXTIE] && gate_q[`CICR_BIT_EXTF]
        |=> core_irq_req)
        else $error("Enabled external flag did not request the core");

    chk_port_path: assert property (
        gate_q[`CICR_BIT_GIE] && gate_q[`CICR_BIT_PCIE] && gate_q[`CICR_BIT_PCF]
        |=> core_irq_req)
        else $error("Enabled port change flag did not request the core");

    chk_timer_flag_set: assert property (
        timer_overflow |=> gate_q[`CICR_BIT_T0F])
        else $error("Timer overflow did not set its flag");

    chk_ext_flag_sticky: assert property (
        gate_q[`CICR_BIT_EXTF] && !gate_wr |=> gate_q[`CICR_BIT_EXTF])
        else $error("External flag dropped without a software write");

    chk_port_flag_set: assert property (
        port_evt |=> gate_q[`CICR_BIT_PCF])
        else $error("Port change did not set its flag");

    chk_flag_ignores_en: assert property (
        ext_edge && !gate_q[`CICR_BIT_EXTIE] |=> gate_q[`CICR_BIT_EXTF])
        else $error("External flag not set while its enable is clear");

    chk_mask_gates_port: assert property (
        ((pins_if.chg[`CICR_NPINS-1:0] & mask_q[`CICR_NPINS-1:0]) == 16'h0000)
        && !gate_q[`CICR_BIT_PCF] && !gate_wr |=> !gate_q[`CICR_BIT_PCF])
        else $error("Masked pin change set the port change flag");

    chk_core_cause: assert property (
        core_irq_req |-> $past(gate_q[`CICR_BIT_GIE]) && $past(src_req))
        else $error("Core request without an enabled cause");

    chk_irq_level: assert property (
        (|(sts_q & en_q)) |=> irq)
        else $error("Enabled status bit did not raise the interrupt");

    chk_irq_low: assert property (
        !(|(sts_q & en_q)) |=> !irq)
        else $error("Interrupt high with no enabled status bit");

    chk_ready_one_cycle: assert property (
        pready |=> !pready)
        else $error("pready stood for more than one cycle");

    chk_err_with_ready: assert property (
        pslverr |-> pready)
        else $error("pslverr raised without pready");

    chk_err_unmapped: assert property (
        first && !mapped |=> pslverr)
        else $error("Unmapped access answered without an error");

    chk_read_gate: assert property (
        first && !pwrite && sel_gate |=> prdata[7:0] == $past(gate_q))
        else $error("Read of the gate register returned a stale value");

    chk_strb_holds_gate: assert property (
        wr_fire && sel_gate && !pstrb[0] && (hw_set == 8'h00) |=> $stable(gate_q))
        else $error("Gate register changed on a write with lane 0 off");

    chk_gate_write_lands: assert property (
        gate_wr && (hw_set == 8'h00) |=> gate_q == $past(pwdata[7:0]))
        else $error("Gate register did not take the written value");

    // A clear racing an overflow must not lose the event
    chk_set_beats_clear: assert property (
        gate_wr && timer_overflow |=> gate_q[`CICR_BIT_T0F])
        else $error("Software clear beat a timer overflow in the same cycle");

    chk_periph_path: assert property (
        gate_q[`CICR_BIT_GIE] && gate_q[`CICR_BIT_PERIPHERAL_GROUP_IRQ_ENABLE] && periph_irq |=> core_irq_req)
        else $error("Enabled peripheral request did not reach the core");

    sequence s_ext_wanted;
        pins_if.chg[`CICR_BIT_EXTPIN]
        && (pins_if.level[`CICR_BIT_EXTPIN] == mask_q[`CICR_BIT_EDGE]);
    endsequence

    sequence s_ext_other;
        pins_if.chg[`CICR_BIT_EXTPIN]
        && (pins_if.level[`CICR_BIT_EXTPIN] != mask_q[`CICR_BIT_EDGE]);
    endsequence

    chk_ext_edge_sets: assert property (
        s_ext_wanted |=> gate_q[`CICR_BIT_EXTF] && sts_q[`CICR_EVT_EXT])
        else $error("Selected pin edge did not set the external flag");

    chk_ext_edge_ignored: assert property (
        s_ext_other ##0 (!gate_q[`CICR_BIT_EXTF] && !gate_wr) |=> !gate_q[`CICR_BIT_EXTF])
        else $error("Unselected pin edge set the external flag");

    chk_sts_sticky: assert property (
        !clr_wr |=> (sts_q & $past(sts_q)) == $past(sts_q))
        else $error("Status bit dropped without a clear write");

    chk_sts_set_wins: assert property (
        evt != 3'h0 |=> (sts_q & $past(evt)) == $past(evt))
        else $error("Event did not set its status bit");

    chk_sts_clear: assert property (
        clr_wr && (evt == 3'h0) |=> (sts_q & $past(pwdata[`CICR_NEVT-1:0])) == 3'h0)
        else $error("Clear write left a status bit set");

    chk_sts_read_only: assert property (
        wr_fire && sel_sts && (evt == 3'h0) |=> $stable(sts_q))
        else $error("Write to the status register changed it");
endmodule : cicr_top

// ### verif/cicr_source_model.sv
// Partner model: timer overflow logic, peripheral flag logic and the two pin groups.
// Assumes its tasks are called at a rising edge of pclk.
`timescale 1ns/1ps
`include "cicr_consts.svh"

module cicr_source_model (
    input  wire logic                   pclk,
    output logic                        timer_overflow,
    output logic                        periph_irq,
    output logic                        external_interrupt_pin,
    output logic [`CICR_NPINS-1:0]      general_io_ports
);
    initial begin
        timer_overflow         = 1'b0;
        periph_irq             = 1'b0;
        external_interrupt_pin = 1'b0;
        general_io_ports       = 16'h0000;
    end

    // ****************************************************************
    // Event sources
    // ****************************************************************
    // One-cycle pulse, as the timer gives it when its count wraps
    task automatic overflow();
        timer_overflow <= 1'b1;
        @(posedge pclk);
        timer_overflow <= 1'b0;
        @(posedge pclk);
    endtask : overflow

    // Pins are asynchronous; each level is held past the synchroniser delay
    task automatic set_ext(input logic v);
        external_interrupt_pin <= v;
        repeat (6) @(posedge pclk);
    endtask : set_ext

    task automatic flip_port(input int idx);
        general_io_ports[idx] <= ~general_io_ports[idx];
        repeat (6) @(posedge pclk);
    endtask : flip_port

    task automatic set_periph(input logic v);
        periph_irq <= v;
        @(posedge pclk);
    endtask : set_periph
endmodule : cicr_source_model

// ### verif/core_interrupt_control_register_test.sv
// Self-checking bench of the core interrupt gate over APB.
// Assumes cicr_top, cicr_source_model and cicr_consts.svh are compiled.
`timescale 1ns/1ps
`include "cicr_consts.svh"

`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin bad_count++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end

module core_interrupt_control_register_test;
    logic                   pclk = 1'b0;
    logic                   presetn = 1'b0;
    logic                   psel = 1'b0;
    logic                   penable = 1'b0;
    logic                   pwrite = 1'b0;
    logic [11:0]            paddr = 12'h000;
    logic [31:0]            pwdata = 32'h0000_0000;
    logic [3:0]             pstrb = 4'hf;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic                   timer_overflow;
    logic                   periph_irq;
    logic                   external_interrupt_pin;
    logic [`CICR_NPINS-1:0] general_io_ports;
    logic                   core_irq_req;
    logic                   irq;
    logic [31:0]            rd_v;
    logic                   err_v;
    int                     bad_count = 0;
    int                     compares = 0;

    always #5 pclk = ~pclk;

    cicr_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_overflow(timer_overflow),
        .periph_irq(periph_irq), .external_interrupt_pin(external_interrupt_pin),
        .general_io_ports(general_io_ports), .core_irq_req(core_irq_req), .irq(irq));

    cicr_source_model src_u (.pclk(pclk), .timer_overflow(timer_overflow),
        .periph_irq(periph_irq), .external_interrupt_pin(external_interrupt_pin),
        .general_io_ports(general_io_ports));

    // ****************************************************************
    // APB master tasks
    // ****************************************************************
    // Holds the request until pready is seen high; only the watchdog ends a hung wait.
    // The extra edge at the end keeps two transfers from assigning psel in one time step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rdchk(input logic [11:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0000_0000);
        `CHK("register read", ex, rd_v)
    endtask : rdchk

    // Request and irq are flops fed by flops, so two edges let them land
    task automatic req_chk(input logic ex);
        repeat (2) @(posedge pclk);
        `CHK("core_irq_req", ex, core_irq_req)
    endtask : req_chk

    task automatic irq_chk(input logic ex);
        repeat (2) @(posedge pclk);
        `CHK("irq", ex, irq)
    endtask : irq_chk

    task automatic report_and_stop();
        if (bad_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    initial begin
        #100us;
        bad_count++;
        report_and_stop();
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(`CICR_OFS_GATE, 32'h0000_0000);
        rdchk(`CICR_OFS_MASK, 32'h0001_0000);
        rdchk(`CICR_OFS_STS, 32'h0000_0000);
        rdchk(`CICR_OFS_EN, 32'h0000_0000);
        rdchk(12'h014, 32'h0000_0000);
        `CHK("pslverr", 1'b1, err_v)
        src_u.overflow();
        rdchk(`CICR_OFS_GATE, 32'h0000_0004);
        `CHK("pslverr", 1'b0, err_v)
        req_chk(1'b0);
        apb(1'b1, `CICR_OFS_GATE, 32'h0000_0024);
        req_chk(1'b0);
        apb(1'b1, `CICR_OFS_GATE, 32'h0000_00a4);
        req_chk(1'b1);
        apb(1'b1, `CICR_OFS_GATE, 32'h0000_0084);
        req_chk(1'b0);
        apb(1'b1, `CICR_OFS_GATE, 32'h0000_00a0);
        req_chk(1'b0);
        pstrb <= 4'he;
        apb(1'b1, `CICR_OFS_GATE, 32'h0000_00ff);
        pstrb <= 4'hf;
        rdchk(`CICR_OFS_GATE, 32'h0000_00a0);
        src_u.set_ext(1'b1);
        rdchk(`CICR_OFS_GATE, 32'h0000_00a2);
        req_chk(1'b0);
        apb(1'b1, `CICR_OFS_GATE, 32'h0000_0092);
        req_chk(1'b1);
        apb(1'b1, `CICR_OFS_GATE, 32'h0000_0090);
        req_chk(1'b0);
        src_u.flip_port(5);
        rdchk(`CICR_OFS_GATE, 32'h0000_0090);
        apb(1'b1, `CICR_OFS_MASK, 32'h0001_0020);
        src_u.flip_port(5);
        rdchk(`CICR_OFS_GATE, 32'h0000_0091);
        req_chk(1'b0);
        apb(1'b1, `CICR_OFS_GATE, 32'h0000_0089);
        req_chk(1'b1);
        apb(1'b1, `CICR_OFS_GATE, 32'h0000_0088);
        req_chk(1'b0);
        src_u.set_periph(1'b1);
        apb(1'b1, `CICR_OFS_GATE, 32'h0000_0080);
        req_chk(1'b0);
        apb(1'b1, `CICR_OFS_GATE, 32'h0000_00c0);
        req_chk(1'b1);
        apb(1'b1, `CICR_OFS_GATE, 32'h0000_0040);
        req_chk(1'b0);
        src_u.set_periph(1'b0);
        apb(1'b1, `CICR_OFS_STS, 32'h0000_0000);
        rdchk(`CICR_OFS_STS, 32'h0000_0007);
        apb(1'b1, `CICR_OFS_EN, 32'h0000_0001);
        irq_chk(1'b1);
        apb(1'b1, `CICR_OFS_EN, 32'h0000_0000);
        irq_chk(1'b0);
        apb(1'b1, `CICR_OFS_CLR, 32'h0000_0007);
        rdchk(`CICR_OFS_STS, 32'h0000_0000);
        rdchk(`CICR_OFS_CLR, 32'h0000_0000);
        apb(1'b1, `CICR_OFS_EN, 32'h0000_0007);
        irq_chk(1'b0);
        // Falling edge select: a fall sets the flag, a rise does not
        apb(1'b1, `CICR_OFS_MASK, 32'h0000_0020);
        src_u.set_ext(1'b0);
        rdchk(`CICR_OFS_GATE, 32'h0000_0042);
        irq_chk(1'b1);
        apb(1'b1, `CICR_OFS_GATE, 32'h0000_0000);
        apb(1'b1, `CICR_OFS_CLR, 32'h0000_0002);
        src_u.set_ext(1'b1);
        rdchk(`CICR_OFS_GATE, 32'h0000_0000);
        irq_chk(1'b0);
        // Overflow lands on the very edge that writes the flag clear: the set wins
        fork
            apb(1'b1, `CICR_OFS_GATE, 32'h0000_0020);
            begin
                repeat (2) @(posedge pclk);
                src_u.overflow();
            end
        join
        rdchk(`CICR_OFS_GATE, 32'h0000_0024);
        irq_chk(1'b1);
        report_and_stop();
    end
endmodule : core_interrupt_control_register_test
